// ### hw/ppt_pkg.sv
// Package: register map, field layouts and timing of the port timers
// Function
// - Stale timer runs only while the FIFO receives, never on transmit.
// - Each received character reloads countdown from period and starts ticking.
// - Countdown reaching zero sets the stale flag in FIFO status.
// - Stale with a whole word available requests DMA of remaining words.
// - After stale DMA finishes, a single leftover byte raises a host interrupt.
// - Device reset or FIFO reset clears the countdown to zero.
// - Clearing the countdown makes the stale flag true.
// - Period register cleared by device reset only, kept on FIFO reset.
// - Tick is clock divided by 250 then by ten: 0.1 ms at 25 MHz.
// - Divide-by-ten prescaler restarts whenever the countdown reloads.
// - EPP address write stores the byte; EPP address read returns it.
// - Host wait limit resets to all ones.
// - Host timer is a 14-bit up-counter on clock divided by 2048.
// - Each host-awaiting event restarts the counter from zero; counts until answered.
// - Upper eight counter bits equal to limit means host timeout.
// - Timeout raises negotiation change interrupt and reports 0x22 as result.
// - After timeout, control stays locked until link returns to compatibility idle.
// - Both host timer test bits set suppress every host timeout.
// - Pin view: bit3 active, bit2 init low, bit1 busy, bit0 strobe; rest zero.
// - FIFO timeout flag sets on each false-to-true stale transition.
package ppt_pkg;
   // -----------------------------------------------------------
   // Register byte addresses (index times four)
   // -----------------------------------------------------------
   localparam logic [7:0] IDX_HOST_WAIT_LIMIT = 8'h24;
   localparam logic [7:0] IDX_ADDR_LATCH      = 8'h25;
   localparam logic [7:0] IDX_STALE_PERIOD    = 8'h3C;
   localparam logic [7:0] IDX_STALE_COUNT     = 8'h3D;
   localparam logic [7:0] IDX_PIN_VIEW        = 8'h40;
   localparam logic [7:0] IDX_FIFO_STATUS     = 8'h41;
   localparam logic [7:0] IDX_NEG_RESULT      = 8'h42;
   localparam logic [7:0] IDX_PORT_CONTROL    = 8'h43;
   localparam logic [9:0] ADDR_HOST_WAIT_LIMIT = {IDX_HOST_WAIT_LIMIT, 2'b00};
   localparam logic [9:0] ADDR_ADDR_LATCH      = {IDX_ADDR_LATCH, 2'b00};
   localparam logic [9:0] ADDR_STALE_PERIOD    = {IDX_STALE_PERIOD, 2'b00};
   localparam logic [9:0] ADDR_STALE_COUNT     = {IDX_STALE_COUNT, 2'b00};
   localparam logic [9:0] ADDR_PIN_VIEW        = {IDX_PIN_VIEW, 2'b00};
   localparam logic [9:0] ADDR_FIFO_STATUS     = {IDX_FIFO_STATUS, 2'b00};
   localparam logic [9:0] ADDR_NEG_RESULT      = {IDX_NEG_RESULT, 2'b00};
   localparam logic [9:0] ADDR_PORT_CONTROL    = {IDX_PORT_CONTROL, 2'b00};
   // -----------------------------------------------------------
   // Reset values and fields
   // -----------------------------------------------------------
   localparam logic [7:0] RST_HOST_WAIT_LIMIT = 8'hFF;
   localparam logic [7:0] RST_ZERO            = 8'h00;
   localparam logic [7:0] NEG_HOST_TIMEOUT    = 8'h22;
   localparam int         FST_TIMEOUT_BIT     = 5;
   localparam int         FST_STALE_BIT       = 2;
   localparam int         FST_ONECHAR_BIT     = 1;
   localparam int         PCR_TEST_LO         = 2;
   localparam int         PCR_TEST_HI         = 3;
   localparam int         PCR_CLEAR_TO_BIT    = 0;
   // -----------------------------------------------------------
   // Timing
   // -----------------------------------------------------------
   localparam int CLK_HZ           = 25_000_000;
   localparam int STALE_DIV        = 250;
   localparam int STALE_PRESCALE   = 10;
   localparam int HOST_DIV         = 2048;
   localparam int HOST_CNT_W       = 14;
   localparam logic [7:0] STALE_DIV_LAST = 8'(STALE_DIV - 1);
   localparam logic [3:0] STALE_PRE_LAST = 4'(STALE_PRESCALE - 1);
   localparam logic [10:0] HOST_DIV_LAST = 11'(HOST_DIV - 1);
   // -----------------------------------------------------------
   // Types
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      PPT_IDLE   = 2'b00,
      PPT_WAIT   = 2'b01,
      PPT_LOCKED = 2'b11
   } ppt_host_state_t;
   typedef struct packed {
      logic ieee_active_input;
      logic init_input_low;
      logic host_busy_input;
      logic host_strobe_input;
   } ppt_pins_t;
endpackage

// ### hw/ppt_timers.sv
// Module: stale-data timer, host timeout timer, EPP address, pin view
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ppt_timers
   import ppt_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   // AXI4-Lite slave
   input  wire logic [9:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [9:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // FIFO side events (same clock)
   input  wire logic        fifo_reset_in,
   input  wire logic        fifo_receive_in,
   input  wire logic        rx_char_write_in,
   input  wire logic        word_available_in,
   input  wire logic        odd_byte_left_in,
   input  wire logic        dma_done_in,
   // Port state machine side (same clock)
   input  wire logic        host_wait_start_in,
   input  wire logic        host_event_in,
   input  wire logic        epp_mode_in,
   input  wire logic        epp_addr_write_in,
   input  wire logic [7:0]  epp_addr_data_in,
   // Handshake pins (asynchronous)
   input  wire ppt_pins_t   pins_in,
   // Outputs
   output logic             stale_dma_req_out,
   output logic             one_char_irq_out,
   output logic             neg_change_irq_out,
   output logic             host_timeout_out,
   output logic             control_locked_out,
   output logic [7:0]       epp_addr_read_out
);
   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   logic [7:0]      host_wait_limit;
   logic [7:0]      parallel_address_latch;
   logic [7:0]      stale_period_value;
   logic [7:0]      stale_countdown;
   logic [7:0]      negotiation_result_reg;
   logic [7:0]      port_control_reg;
   logic            stale_flag;
   logic            fifo_timeout_flag;
   logic            one_char_flag;
   logic            dma_pending;
   logic [7:0]      div250;
   logic [3:0]      pre10;
   logic [10:0]     div2048;
   logic [HOST_CNT_W-1:0] host_count;
   ppt_host_state_t host_state;
   logic [3:0]      pin_s1, pin_s2, pin_s3, pin_view;

   // -----------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------
   logic       wr_fire, rd_fire, clr_to_req;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic       rd_hit;
   logic [7:0] fifo_status;
   assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out
                    && !s_axi_awready_out;
   assign rd_fire = s_axi_arvalid_in && !s_axi_rvalid_out
                    && !s_axi_arready_out;
   assign wbyte   = s_axi_wdata_in[7:0];
   wire wr_en     = wr_fire && s_axi_wstrb_in[0];
   wire wr_limit  = wr_en && s_axi_awaddr_in == ADDR_HOST_WAIT_LIMIT;
   wire wr_latch  = wr_en && s_axi_awaddr_in == ADDR_ADDR_LATCH;
   wire wr_period = wr_en && s_axi_awaddr_in == ADDR_STALE_PERIOD;
   wire wr_count  = wr_en && s_axi_awaddr_in == ADDR_STALE_COUNT;
   wire wr_pcr    = wr_en && s_axi_awaddr_in == ADDR_PORT_CONTROL;
   wire wr_neg    = wr_en && s_axi_awaddr_in == ADDR_NEG_RESULT;
   assign clr_to_req = wr_pcr && wbyte[PCR_CLEAR_TO_BIT];
   assign fifo_status = {2'b00, fifo_timeout_flag, 2'b00, stale_flag,
                         one_char_flag, 1'b0};
   assign rd_hit = s_axi_araddr_in == ADDR_HOST_WAIT_LIMIT
                || s_axi_araddr_in == ADDR_ADDR_LATCH
                || s_axi_araddr_in == ADDR_STALE_PERIOD
                || s_axi_araddr_in == ADDR_STALE_COUNT
                || s_axi_araddr_in == ADDR_PIN_VIEW
                || s_axi_araddr_in == ADDR_FIFO_STATUS
                || s_axi_araddr_in == ADDR_NEG_RESULT
                || s_axi_araddr_in == ADDR_PORT_CONTROL;
   assign rd_byte =
      (s_axi_araddr_in == ADDR_HOST_WAIT_LIMIT) ? host_wait_limit :
      (s_axi_araddr_in == ADDR_ADDR_LATCH)      ? parallel_address_latch :
      (s_axi_araddr_in == ADDR_STALE_PERIOD)    ? stale_period_value :
      (s_axi_araddr_in == ADDR_STALE_COUNT)     ? stale_countdown :
      (s_axi_araddr_in == ADDR_PIN_VIEW)        ? {4'h0, pin_view} :
      (s_axi_araddr_in == ADDR_FIFO_STATUS)     ? fifo_status :
      (s_axi_araddr_in == ADDR_NEG_RESULT)      ? negotiation_result_reg :
      (s_axi_araddr_in == ADDR_PORT_CONTROL)    ? port_control_reg :
                                                  8'h00;
   wire wr_hit = s_axi_awaddr_in == ADDR_HOST_WAIT_LIMIT
              || s_axi_awaddr_in == ADDR_ADDR_LATCH
              || s_axi_awaddr_in == ADDR_STALE_PERIOD
              || s_axi_awaddr_in == ADDR_STALE_COUNT
              || s_axi_awaddr_in == ADDR_NEG_RESULT
              || s_axi_awaddr_in == ADDR_PORT_CONTROL
              || s_axi_awaddr_in == ADDR_PIN_VIEW
              || s_axi_awaddr_in == ADDR_FIFO_STATUS;

   // -----------------------------------------------------------
   // AXI handshake
   // -----------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= 2'b00;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rresp_out   <= 2'b00;
         s_axi_rdata_out   <= 32'h0000_0000;
      end
      else
      begin
         s_axi_awready_out <= wr_fire;
         s_axi_wready_out  <= wr_fire;
         s_axi_arready_out <= rd_fire;
         if (wr_fire)
         begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? 2'b00 : 2'b10;
         end
         else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
         if (rd_fire)
         begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= {24'h00_0000, rd_byte};
            s_axi_rresp_out  <= rd_hit ? 2'b00 : 2'b10;
         end
         else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // Pin synchroniser, three stages, accept on agreement
   // -----------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      pin_s1 <= pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (reset_in)
         pin_view <= 4'h0;
      else
         pin_view <= (pin_s2 & pin_s3) | (pin_view & (pin_s2 | pin_s3));
   end

   // -----------------------------------------------------------
   // Stale-data timer
   // -----------------------------------------------------------
   wire reload    = fifo_receive_in && rx_char_write_in;
   wire div_tick  = div250 == STALE_DIV_LAST;
   wire stale_tick = div_tick && pre10 == STALE_PRE_LAST;
   wire count_dec = fifo_receive_in && stale_tick
                    && stale_countdown != 8'h00;
   wire next_zero = fifo_reset_in || (wr_count && wbyte == 8'h00)
                    || (count_dec && !wr_count
                        && stale_countdown == 8'h01);
   // FIFO reset clears the count, so stale must follow it
   wire next_stale = fifo_reset_in ? 1'b1 :
                     reload ? (stale_period_value == 8'h00) :
                     (next_zero ? 1'b1 :
                      (wr_count ? 1'b0 : stale_flag));
   wire stale_rise = next_stale && !stale_flag;

   always_ff @(posedge clk_in)
   begin
      if (reset_in || reload)
      begin
         div250 <= 8'h00;
         pre10  <= 4'h0;
      end
      else
      begin
         div250 <= div_tick ? 8'h00 : div250 + 8'h01;
         if (div_tick)
            pre10 <= (pre10 == STALE_PRE_LAST) ? 4'h0 : pre10 + 4'h1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         stale_period_value <= RST_ZERO;
      else if (wr_period)
         stale_period_value <= wbyte;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in || fifo_reset_in)
         stale_countdown <= RST_ZERO;
      else if (reload)
         stale_countdown <= stale_period_value;
      else if (wr_count)
         stale_countdown <= wbyte;
      else if (count_dec)
         stale_countdown <= stale_countdown - 8'h01;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         stale_flag        <= 1'b1;
         fifo_timeout_flag <= 1'b0;
         dma_pending       <= 1'b0;
         one_char_flag     <= 1'b0;
         stale_dma_req_out <= 1'b0;
         one_char_irq_out  <= 1'b0;
      end
      else
      begin
         stale_flag <= next_stale;
         if (stale_rise)
            fifo_timeout_flag <= 1'b1;
         else if (clr_to_req || fifo_reset_in)
            fifo_timeout_flag <= 1'b0;
         if (stale_rise && fifo_receive_in && word_available_in)
            dma_pending <= 1'b1;
         else if (dma_done_in || reload || fifo_reset_in)
            dma_pending <= 1'b0;
         stale_dma_req_out <= dma_pending && word_available_in;
         if (stale_flag && fifo_receive_in && odd_byte_left_in
             && !word_available_in && (dma_done_in || !dma_pending))
            one_char_flag <= 1'b1;
         else if (reload || fifo_reset_in || !odd_byte_left_in)
            one_char_flag <= 1'b0;
         one_char_irq_out <= one_char_flag;
      end
   end

   // -----------------------------------------------------------
   // EPP address latch
   // -----------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         parallel_address_latch <= RST_ZERO;
      else if (epp_mode_in && epp_addr_write_in)
         parallel_address_latch <= epp_addr_data_in;
      else if (wr_latch)
         parallel_address_latch <= wbyte;
      if (reset_in)
         epp_addr_read_out <= RST_ZERO;
      else
         epp_addr_read_out <= parallel_address_latch;
   end

   // -----------------------------------------------------------
   // Host timeout timer
   // -----------------------------------------------------------
   wire host_div_tick = div2048 == HOST_DIV_LAST;
   wire timers_off = port_control_reg[PCR_TEST_HI]
                     && port_control_reg[PCR_TEST_LO];
   wire host_match = host_state == PPT_WAIT && !timers_off
                     && host_count[HOST_CNT_W-1 -: 8] == host_wait_limit;
   wire link_idle = pin_view[2] && !pin_view[3];

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         host_wait_limit <= RST_HOST_WAIT_LIMIT;
         port_control_reg <= RST_ZERO;
      end
      else
      begin
         if (wr_limit)
            host_wait_limit <= wbyte;
         if (wr_pcr)
            port_control_reg <= wbyte & 8'hFE;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in || host_wait_start_in)
      begin
         div2048    <= 11'h000;
         host_count <= 14'h0000;
      end
      else if (host_state == PPT_WAIT)
      begin
         div2048 <= div2048 + 11'h001;
         if (host_div_tick)
            host_count <= host_count + 14'h0001;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         host_state             <= PPT_IDLE;
         negotiation_result_reg <= RST_ZERO;
         neg_change_irq_out     <= 1'b0;
         host_timeout_out       <= 1'b0;
         control_locked_out     <= 1'b0;
      end
      else
      begin
         neg_change_irq_out <= host_match;
         host_timeout_out   <= host_match;
         if (host_match)
            negotiation_result_reg <= NEG_HOST_TIMEOUT;
         else if (wr_neg)
            negotiation_result_reg <= wbyte;
         unique case (host_state)
            PPT_IDLE:
               if (host_wait_start_in)
                  host_state <= PPT_WAIT;
            PPT_WAIT:
               if (host_match)
                  host_state <= PPT_LOCKED;
               else if (host_event_in && !host_wait_start_in)
                  host_state <= PPT_IDLE;
            PPT_LOCKED:
               if (link_idle)
                  host_state <= PPT_IDLE;
            default:
               host_state <= PPT_IDLE;
         endcase
         control_locked_out <= (host_state == PPT_LOCKED && !link_idle)
                               || host_match;
      end
   end

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   property p_count_zero_after_fifo_reset;
      @(posedge clk_in) disable iff (reset_in)
      fifo_reset_in |=> stale_countdown == 8'h00 && stale_flag;
   endproperty
   a_count_zero_after_fifo_reset: assert property (p_count_zero_after_fifo_reset)
      else $error("Countdown not cleared by FIFO reset");

   property p_reload;
      @(posedge clk_in) disable iff (reset_in)
      reload && !fifo_reset_in |=> stale_countdown == $past(stale_period_value)
                                   && pre10 == 4'h0;
   endproperty
   a_reload: assert property (p_reload)
      else $error("Countdown did not reload from period");

   property p_hold_zero;
      @(posedge clk_in) disable iff (reset_in)
      stale_countdown == 8'h00 && !reload && !wr_count |=>
         stale_countdown == 8'h00;
   endproperty
   a_hold_zero: assert property (p_hold_zero)
      else $error("Countdown left zero without reload");

   property p_period_kept;
      @(posedge clk_in) disable iff (reset_in)
      fifo_reset_in && !wr_period |=> $stable(stale_period_value);
   endproperty
   a_period_kept: assert property (p_period_kept)
      else $error("Period changed by FIFO reset");

   property p_no_tx_count;
      @(posedge clk_in) disable iff (reset_in)
      !fifo_receive_in && !wr_count && !fifo_reset_in |=>
         $stable(stale_countdown);
   endproperty
   a_no_tx_count: assert property (p_no_tx_count)
      else $error("Stale timer moved outside receive");

   property p_timeout_result;
      @(posedge clk_in) disable iff (reset_in)
      host_match |=> negotiation_result_reg == 8'h22 && neg_change_irq_out
                     && host_state == PPT_LOCKED;
   endproperty
   a_timeout_result: assert property (p_timeout_result)
      else $error("Host timeout not reported");

   property p_test_bits;
      @(posedge clk_in) disable iff (reset_in)
      timers_off |=> !host_timeout_out;
   endproperty
   a_test_bits: assert property (p_test_bits)
      else $error("Timeout while timer disabled");

   property p_timeout_flag;
      @(posedge clk_in) disable iff (reset_in)
      !stale_flag ##1 stale_flag |-> fifo_timeout_flag;
   endproperty
   a_timeout_flag: assert property (p_timeout_flag)
      else $error("Timeout flag missed stale rise");

   property p_pin_view_high_zero;
      @(posedge clk_in) disable iff (reset_in)
      rd_fire |=> s_axi_rdata_out[31:8] == 24'h00_0000;
   endproperty
   a_pin_view_high_zero: assert property (p_pin_view_high_zero)
      else $error("Upper read bits not zero");
endmodule

// ### test/ppt_host_model.sv
// Remote host model: answers awaited events, drives handshake pins
`timescale 1ns/1ps
module ppt_host_model
   import ppt_pkg::*;
(
   // Clock and bench control
   input  wire logic      clk_in,
   input  wire logic      slow_in,
   input  wire ppt_pins_t pins_set_in,
   // Link side
   input  wire logic      wait_start_in,
   output logic           host_event_out,
   output ppt_pins_t      pins_out
);
   logic [3:0] delay = 4'h0;
   initial host_event_out = 1'b0;
   assign pins_out = pins_set_in;
   // Prompt answer after four cycles, none when slow
   always @(posedge clk_in)
   begin
      host_event_out <= (delay == 4'h1);
      if (wait_start_in && !slow_in)
         delay <= 4'h4;
      else if (delay != 4'h0)
         delay <= delay - 4'h1;
   end
endmodule

// ### test/parallel_port_timers_tb_top.sv
// Testbench: register and event sequences for the port timers
`timescale 1ns/1ps
module parallel_port_timers_tb_top
   import ppt_pkg::*;
;
   logic clk_in = 1'b0, reset_in = 1'b1, slow = 1'b1;
   logic [9:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
   logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, rv;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_awready_out;
   logic s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, host_event_in, stale_dma_req_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rr, seen = 2'b00;
   logic fifo_reset_in = 0, fifo_receive_in = 0, rx_char_write_in = 0;
   logic word_available_in = 0, odd_byte_left_in = 0, dma_done_in = 0;
   logic host_wait_start_in = 0, epp_mode_in = 0, epp_addr_write_in = 0;
   logic [7:0] epp_addr_data_in = '0, epp_addr_read_out;
   logic one_char_irq_out, neg_change_irq_out, host_timeout_out;
   logic control_locked_out;
   ppt_pins_t pins_in, pins_set = 4'h4;
   int failures = 0, n_tests = 0;
   ppt_timers DUT (.clk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
      .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
      .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
      .s_axi_rvalid_out, .s_axi_rready_in, .fifo_reset_in, .fifo_receive_in,
      .rx_char_write_in, .word_available_in, .odd_byte_left_in, .dma_done_in,
      .host_wait_start_in, .host_event_in, .epp_mode_in, .epp_addr_write_in,
      .epp_addr_data_in, .pins_in, .stale_dma_req_out, .one_char_irq_out,
      .neg_change_irq_out, .host_timeout_out, .control_locked_out,
      .epp_addr_read_out);
   ppt_host_model host (.clk_in, .slow_in(slow), .pins_set_in(pins_set),
      .wait_start_in(host_wait_start_in), .host_event_out(host_event_in),
      .pins_out(pins_in));
   always #20 clk_in = ~clk_in;
   always @(posedge clk_in)
      seen <= seen | {neg_change_irq_out === 1'b1, host_timeout_out === 1'b1};
   // ---------------------------------------------
   // Bus tasks and comparison
   // ---------------------------------------------
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {s_axi_awaddr_in, s_axi_wdata_in, s_axi_awvalid_in, s_axi_wvalid_in,
         s_axi_bready_in} <= {a, d, 3'b111};
      do @(posedge clk_in); while (s_axi_awready_out !== 1'b1);
      {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'b00;
      while (s_axi_bvalid_out !== 1'b1) @(posedge clk_in);
      rr = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge clk_in);
      {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'b11};
      do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      while (s_axi_rvalid_out !== 1'b1) @(posedge clk_in);
      rv = s_axi_rdata_out;
      rr = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("BAD at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task automatic end_of_test;
      if (failures == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk_in);
      failures++;
      end_of_test();
   end
   initial
   begin
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      rdchk(ADDR_HOST_WAIT_LIMIT, 32'h0000_00FF);
      rdchk(ADDR_STALE_PERIOD, 32'h0);
      rdchk(ADDR_STALE_COUNT, 32'h0);
      rd(ADDR_FIFO_STATUS);
      chk(rv & 32'h4, 32'h4);
      rdchk(ADDR_PIN_VIEW, 32'h4);
      pins_set <= 4'hB;
      repeat (4) @(posedge clk_in);
      rdchk(ADDR_PIN_VIEW, 32'hB);
      rd(10'h3FC);
      chk(rr, 2'b10);
      wr(10'h3FC, 32'h0);
      chk(rr, 2'b10);
      {epp_mode_in, epp_addr_data_in, epp_addr_write_in} <= {1'b1, 8'hA5, 1'b1};
      @(posedge clk_in);
      epp_addr_write_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(epp_addr_read_out, 32'hA5);
      rdchk(ADDR_ADDR_LATCH, 32'hA5);
      wr(ADDR_PORT_CONTROL, 32'h1);
      wr(ADDR_STALE_PERIOD, 32'h1);
      {fifo_receive_in, word_available_in, rx_char_write_in} <= 3'b111;
      @(posedge clk_in);
      rx_char_write_in <= 1'b0;
      repeat (2200) @(posedge clk_in);
      rdchk(ADDR_STALE_COUNT, 32'h1);
      rd(ADDR_FIFO_STATUS);
      chk(rv & 32'h24, 32'h0);
      repeat (400) @(posedge clk_in);
      rdchk(ADDR_STALE_COUNT, 32'h0);
      rd(ADDR_FIFO_STATUS);
      chk(rv & 32'h24, 32'h24);
      chk(stale_dma_req_out, 32'h1);
      repeat (2600) @(posedge clk_in);
      rdchk(ADDR_STALE_COUNT, 32'h0);
      {word_available_in, odd_byte_left_in, dma_done_in} <= 3'b011;
      @(posedge clk_in);
      dma_done_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(one_char_irq_out, 32'h1);
      chk(stale_dma_req_out, 32'h0);
      wr(ADDR_STALE_COUNT, 32'h7);
      fifo_reset_in <= 1'b1;
      @(posedge clk_in);
      fifo_reset_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rdchk(ADDR_STALE_COUNT, 32'h0);
      rdchk(ADDR_STALE_PERIOD, 32'h1);
      rd(ADDR_FIFO_STATUS);
      chk(rv & 32'h4, 32'h4);
      {fifo_receive_in, rx_char_write_in} <= 2'b01;
      @(posedge clk_in);
      rx_char_write_in <= 1'b0;
      rdchk(ADDR_STALE_COUNT, 32'h0);
      wr(ADDR_HOST_WAIT_LIMIT, 32'h1);
      slow <= 1'b0;
      host_wait_start_in <= 1'b1;
      @(posedge clk_in);
      host_wait_start_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      slow <= 1'b1;
      wr(ADDR_HOST_WAIT_LIMIT, 32'h0);
      repeat (5) @(posedge clk_in);
      chk(seen, 32'h0);
      wr(ADDR_PORT_CONTROL, 32'hC);
      wr(ADDR_HOST_WAIT_LIMIT, 32'h0);
      pins_set <= 4'hC;
      host_wait_start_in <= 1'b1;
      @(posedge clk_in);
      host_wait_start_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      chk(seen, 32'h0);
      wr(ADDR_PORT_CONTROL, 32'h0);
      host_wait_start_in <= 1'b1;
      @(posedge clk_in);
      host_wait_start_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      chk(seen, 32'h3);
      rdchk(ADDR_NEG_RESULT, 32'h22);
      chk(control_locked_out, 32'h1);
      pins_set <= 4'h4;
      repeat (10) @(posedge clk_in);
      chk(control_locked_out, 32'h0);
      end_of_test();
   end
endmodule
